// ---- rtl/mps_pkg.sv ----
// Constants and types shared by the module power-state sequencer.
// Assumes a 25 MHz always-on logic clock.
package mps_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned HW_OFF_MIN_NS   = 10_000;
    localparam int unsigned HW_OFF_CYCLES   = (HW_OFF_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PWRUP_CYCLES    = 16;
    localparam int unsigned WAKE_PINS       = 4;
    localparam int unsigned HOLD_W          = 8;
    localparam int unsigned SYNC_STAGES     = 3;

    typedef enum logic [1:0] {
        MPS_OFF,
        MPS_PWRUP,
        MPS_ON,
        MPS_SLEEP
    } mps_state_e;
endpackage

// ---- rtl/mps_sync.sv ----
// Three-stage input synchroniser; a change counts once stages two and three agree.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module mps_sync
    import mps_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
)
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Signal.
    input  wire logic async_in,
    output logic      sync_out
);
    typedef struct packed {
        logic [SYNC_STAGES-1:0] stage;
        logic                   level;
    } mps_sync_s;

    mps_sync_s st_q;
    mps_sync_s st_d;

    always_comb
    begin
        st_d       = st_q;
        st_d.stage = {st_q.stage[SYNC_STAGES-2:0], async_in};
        if (st_q.stage[1] == st_q.stage[2])
        begin
            st_d.level = st_q.stage[2];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '{stage: {SYNC_STAGES{RESET_VAL}}, level: RESET_VAL};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.level;
endmodule

// ---- rtl/mps_timer.sv ----
// Up-counter that reports when a condition has held for a set number of cycles.
// Assumes the condition is already in the clk domain.
`timescale 1ns/1ns
module mps_timer
    import mps_pkg::*;
#(
    parameter int unsigned CYCLES = HW_OFF_CYCLES
)
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Condition and result.
    input  wire logic hold_in,
    output logic      expired
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } mps_timer_s;

    mps_timer_s st_q;
    mps_timer_s st_d;

    always_comb
    begin
        st_d = st_q;
        if (!hold_in)
        begin
            st_d.cnt = '0;
        end
        else if (st_q.cnt != CW'(CYCLES))
        begin
            st_d.cnt = st_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '{cnt: '0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign expired = (st_q.cnt == CW'(CYCLES));
endmodule

// ---- rtl/mps_sequencer.sv ----
// Power-state sequencer of a compute module: OFF, ON and SLEEP with the carrier-board handshake.
// Assumes pins arrive asynchronously and the internal requests are already on clk.
//
// Summary of operation
// - Module releases module reset once internal power-up is done.
// - A low on-request starts the internal shutdown sequence.
// - Thermal, software or under-voltage need drives shutdown request low.
// - On-request low makes module assert reset; carrier supplies may then go off.
// - Only a rising on-request edge with main supply present moves OFF to PWRUP.
// - ON is reachable only from PWRUP or SLEEP.
// - OFF is the reset default; later entered from PWRUP, ON or SLEEP on an off event.
// - On-request low for at least 10 us in ON is a hardware shutdown.
// - Thermal shutdown from any state; software shutdown only in ON with software running.
// - Hardware, software and thermal shutdowns all drive shutdown request low.
// - Supply shutdown waits for on-request low even if request is asserted.
// - SLEEP is entered only from ON and resumes without a full boot.
// - In SLEEP held_outputs keep the live_outputs level from just before entry.
// - SLEEP is left on an internal, pin, temperature or VBUS wake event, or to OFF on on-request low.
// - Temperature outside hot or cold limit during SLEEP forces a wake.
// - When enabled, USB VBUS detection wakes the module from SLEEP.
// - Module reset holds processor and storage in reset and sequences carrier supplies.
// - Power management unit takes power, clock and bus wake requests.
// - Sleep indicator is low while in deep-sleep mode.
// - Recovery strap low at reset release selects USB recovery boot.
`timescale 1ns/1ns
module mps_sequencer
    import mps_pkg::*;
#(
    parameter int unsigned PWRUP_CNT = PWRUP_CYCLES,
    parameter int unsigned NWAKE     = WAKE_PINS,
    parameter int unsigned HOLD_BITS = HOLD_W
)
(
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 reset,
    // Carrier handshake pins.
    input  wire logic                 power_on_req,
    input  wire logic                 main_supply_ok,
    input  wire logic                 module_reset_n_in,
    output logic                      module_reset_n_out,
    output logic                      module_reset_n_oe,
    output logic                      shutdown_req_n_out,
    output logic                      shutdown_req_n_oe,
    output logic                      sleep_indicator_n,
    input  wire logic                 recovery_strap_n,
    // Internal requests.
    input  wire logic                 thermal_unsafe,
    input  wire logic                 sw_shutdown_req,
    input  wire logic                 sw_running,
    input  wire logic                 undervoltage,
    input  wire logic                 sleep_req,
    input  wire logic                 deep_sleep_req,
    input  wire logic                 temp_out_of_limits,
    input  wire logic                 vbus_detect,
    input  wire logic                 vbus_wake_en,
    input  wire logic                 internal_wake,
    input  wire logic [NWAKE-1:0]     wake_pins,
    input  wire logic [NWAKE-1:0]     wake_pin_en,
    // Internal status.
    input  wire logic [HOLD_BITS-1:0] live_outputs,
    output logic [HOLD_BITS-1:0]      held_outputs,
    output logic                      soc_reset,
    output logic                      usb_recovery,
    output logic [1:0]                power_state
);
    localparam int unsigned PW = $clog2(PWRUP_CNT + 1);

    typedef struct packed {
        mps_state_e           state;
        logic [PW-1:0]        pwr_cnt;
        logic                 on_req_prev;
        logic                 shut_req;
        logic                 deep;
        logic                 rst_drive;
        logic                 recovery;
        logic                 ext_rst_prev;
        logic [HOLD_BITS-1:0] held;
        logic                 sleep_n;
        logic [1:0]           state_out;
    } mps_seq_s;

    mps_seq_s st_q;
    mps_seq_s st_d;

    logic on_req_s;
    logic supply_s;
    logic ext_rst_s;
    logic strap_s;
    logic hw_off;

    mps_sync #(.RESET_VAL(1'b0)) u_sync_on (
        .clk      (clk),
        .reset    (reset),
        .async_in (power_on_req),
        .sync_out (on_req_s)
    );

    mps_sync #(.RESET_VAL(1'b0)) u_sync_sup (
        .clk      (clk),
        .reset    (reset),
        .async_in (main_supply_ok),
        .sync_out (supply_s)
    );

    mps_sync #(.RESET_VAL(1'b0)) u_sync_rst (
        .clk      (clk),
        .reset    (reset),
        .async_in (module_reset_n_in),
        .sync_out (ext_rst_s)
    );

    // The strap idles high, so its synchroniser resets high to avoid a false recovery request.
    mps_sync #(.RESET_VAL(1'b1)) u_sync_strap (
        .clk      (clk),
        .reset    (reset),
        .async_in (recovery_strap_n),
        .sync_out (strap_s)
    );

    // Low level must persist the minimum time while ON before it counts.
    mps_timer #(.CYCLES(HW_OFF_CYCLES)) u_hw_off (
        .clk     (clk),
        .reset   (reset),
        .hold_in (!on_req_s && st_q.state == MPS_ON),
        .expired (hw_off)
    );

    function automatic logic any_wake(input logic [NWAKE-1:0] pins, input logic [NWAKE-1:0] en);
        any_wake = |(pins & en);
    endfunction

    always_comb
    begin
        st_d             = st_q;
        st_d.on_req_prev = on_req_s;
        st_d.ext_rst_prev = ext_rst_s;
        case (st_q.state)
            MPS_OFF:
            begin
                st_d.rst_drive = 1'b1;
                st_d.shut_req  = 1'b0;
                st_d.pwr_cnt   = '0;
                if (on_req_s && !st_q.on_req_prev && supply_s)
                begin
                    st_d.state = MPS_PWRUP;
                end
            end
            MPS_PWRUP:
            begin
                if (!on_req_s)
                begin
                    st_d.state = MPS_OFF;
                end
                else if (st_q.pwr_cnt == PW'(PWRUP_CNT))
                begin
                    st_d.rst_drive = 1'b0;
                    st_d.state     = MPS_ON;
                end
                else
                begin
                    st_d.pwr_cnt = st_q.pwr_cnt + PW'(1);
                end
            end
            MPS_ON:
            begin
                // Supply shutdown waits for the carrier, whatever the request says.
                if (hw_off)
                begin
                    st_d.rst_drive = 1'b1;
                    st_d.state     = MPS_OFF;
                end
                else if (sleep_req && !st_q.shut_req)
                begin
                    st_d.held    = live_outputs;
                    st_d.deep    = deep_sleep_req;
                    st_d.sleep_n = !deep_sleep_req;
                    st_d.state   = MPS_SLEEP;
                end
            end
            MPS_SLEEP:
            begin
                if (!on_req_s)
                begin
                    st_d.rst_drive = 1'b1;
                    st_d.deep      = 1'b0;
                    st_d.sleep_n   = 1'b1;
                    st_d.state     = MPS_OFF;
                end
                else if (temp_out_of_limits || (vbus_wake_en && vbus_detect) || internal_wake
                         || any_wake(wake_pins, wake_pin_en))
                begin
                    st_d.deep    = 1'b0;
                    st_d.sleep_n = 1'b1;
                    st_d.state   = MPS_ON;
                end
            end
            default:
            begin
                st_d.state = MPS_OFF;
            end
        endcase
        // The request is sticky so a short internal event still reaches the carrier. It is set after
        // the state decode so that a thermal or supply fault seen in OFF is still raised.
        if ((st_q.state == MPS_ON && sw_shutdown_req && sw_running) || thermal_unsafe || undervoltage
            || hw_off)
        begin
            st_d.shut_req = 1'b1;
        end
        if (st_d.state != MPS_SLEEP)
        begin
            st_d.held = live_outputs;
        end
        // Strap is caught on the cycle the module reset is seen to release.
        if (ext_rst_s && !st_q.ext_rst_prev && st_q.state == MPS_ON)
        begin
            st_d.recovery = !strap_s;
        end
        else if (st_q.state == MPS_OFF)
        begin
            st_d.recovery = 1'b0;
        end
        st_d.state_out = st_d.state;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_q <= '{state: MPS_OFF, pwr_cnt: '0, on_req_prev: 1'b0, shut_req: 1'b0, deep: 1'b0,
                      rst_drive: 1'b1, recovery: 1'b0, ext_rst_prev: 1'b0, held: '0, sleep_n: 1'b1,
                      state_out: 2'h0};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign module_reset_n_out = 1'b0;
    assign module_reset_n_oe  = st_q.rst_drive;
    assign shutdown_req_n_out = 1'b0;
    assign shutdown_req_n_oe  = st_q.shut_req;
    assign sleep_indicator_n  = st_q.sleep_n;
    assign held_outputs       = st_q.held;
    assign soc_reset          = st_q.rst_drive;
    assign usb_recovery       = st_q.recovery;
    assign power_state        = st_q.state_out;

    // Assertion helper: consecutive cycles in ON with the synchronised request low.
    localparam int unsigned LW = $clog2(HW_OFF_CYCLES + 1);

    logic [LW-1:0] low_run_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            low_run_q <= '0;
        end
        else if (on_req_s || st_q.state != MPS_ON)
        begin
            low_run_q <= '0;
        end
        else if (low_run_q != LW'(HW_OFF_CYCLES))
        begin
            low_run_q <= low_run_q + LW'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_off_to_on_edge: assert property ((st_q.state == MPS_OFF && st_d.state != MPS_OFF)
        |-> (on_req_s && !st_q.on_req_prev && supply_s)) else $error("left OFF without on edge");
    a_on_sources: assert property ((st_q.state != MPS_ON && st_d.state == MPS_ON)
        |-> (st_q.state == MPS_PWRUP || st_q.state == MPS_SLEEP)) else $error("ON from bad state");
    a_sleep_only_on: assert property ((st_q.state != MPS_SLEEP && st_d.state == MPS_SLEEP)
        |-> st_q.state == MPS_ON) else $error("SLEEP from bad state");
    a_off_rst_held: assert property (st_q.state == MPS_OFF |=> module_reset_n_oe) else $error("reset not held");
    a_hw_off_time: assert property ($rose(module_reset_n_oe) |-> $past(!on_req_s || hw_off))
        else $error("reset asserted without low request");
    // The helper counts independently of the timer, so a short timer still trips this check.
    a_hw_min_low: assert property ((st_q.state == MPS_ON && st_d.state == MPS_OFF)
        |-> low_run_q == LW'(HW_OFF_CYCLES)) else $error("shutdown too early");
    a_shut_waits: assert property ((st_q.state == MPS_ON && shutdown_req_n_oe && on_req_s && $past(on_req_s))
        |=> st_q.state != MPS_OFF) else $error("shut without low request");
    a_sleep_hold: assert property ((st_q.state == MPS_SLEEP && $past(st_q.state) == MPS_SLEEP)
        |-> $stable(held_outputs)) else $error("outputs moved in sleep");
    a_thermal_req: assert property (thermal_unsafe |=> shutdown_req_n_oe) else $error("no thermal request");
    a_deep_ind: assert property (st_q.state == MPS_SLEEP && st_q.deep |-> !sleep_indicator_n)
        else $error("indicator high in deep sleep");
    a_wake_vbus: assert property ((st_q.state == MPS_SLEEP && on_req_s && vbus_wake_en && vbus_detect)
        |=> st_q.state == MPS_ON) else $error("no vbus wake");
    a_temp_wake: assert property ((st_q.state == MPS_SLEEP && on_req_s && temp_out_of_limits)
        |=> st_q.state == MPS_ON) else $error("no thermal wake");

    c_power_up: cover property (st_q.state == MPS_PWRUP ##[1:40] st_q.state == MPS_ON);
    c_sleep_wake: cover property (st_q.state == MPS_SLEEP ##1 st_q.state == MPS_ON);
    c_hw_shut: cover property (st_q.state == MPS_ON ##1 st_q.state == MPS_OFF);
    c_deep_sleep: cover property (st_q.state == MPS_SLEEP && st_q.deep);
    c_light_sleep: cover property (st_q.state == MPS_SLEEP && !st_q.deep);
endmodule

// ---- bench/mps_carrier.sv ----
// Carrier-board model: main supply, on-request pin and carrier supply enable.
// Assumes the module reset and shutdown request wires arrive resolved, with pull-ups.
`timescale 1ns/1ns
module mps_carrier
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    // Bench commands.
    input  wire logic go,
    input  wire logic off_req,
    input  wire logic ignore_req,
    // Wires to the module.
    input  wire logic module_reset_n,
    input  wire logic shutdown_req_n,
    output logic      power_on_req,
    output logic      main_supply_ok,
    output logic      supply_en
);
    logic lock_q;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            power_on_req   <= 1'b0;
            main_supply_ok <= 1'b0;
            supply_en      <= 1'b0;
            lock_q         <= 1'b0;
        end
        else
        begin
            main_supply_ok <= go;
            // A served request stays served until go is withdrawn, so the module is not rebooted.
            lock_q         <= go & (lock_q | (~shutdown_req_n & ~ignore_req));
            power_on_req   <= go & main_supply_ok & ~off_req & ~lock_q & (shutdown_req_n | ignore_req);
            supply_en      <= module_reset_n & power_on_req;
        end
    end
endmodule

// ---- bench/test_module_power_state_sequencer.sv ----
// Self-checking bench of the power-state sequencer against a carrier model.
// Assumes the default power-up count and a 25 MHz clock.
`timescale 1ns/1ns
module test_module_power_state_sequencer
    import mps_pkg::*;
;
    logic       clk, reset, go, off_req, ign, strap_n, therm, sw_sd, sw_run, uv, slp, dslp;
    logic       temp, vbus, vbus_en, iwake, por, sup_ok, sup_en, rst_out, rst_oe, sd_out, sd_oe;
    logic       sleep_n, soc_rst, usb_rec, rst_wire, sd_wire;
    logic [3:0] wp, wpe;
    logic [7:0] live, held, hexp;
    logic [1:0] pstate;
    int         err_total, comparisons, cycles, k;

    // Open-drain wires: the pull-up wins whenever the module lets go.
    assign rst_wire = rst_oe ? rst_out : 1'b1;
    assign sd_wire  = sd_oe ? sd_out : 1'b1;

    mps_carrier u_mps_carrier (.clk(clk), .reset(reset), .go(go), .off_req(off_req), .ignore_req(ign),
        .module_reset_n(rst_wire), .shutdown_req_n(sd_wire), .power_on_req(por), .main_supply_ok(sup_ok),
        .supply_en(sup_en));

    mps_sequencer u_mps_sequencer (.clk(clk), .reset(reset), .power_on_req(por), .main_supply_ok(sup_ok),
        .module_reset_n_in(rst_wire), .module_reset_n_out(rst_out), .module_reset_n_oe(rst_oe),
        .shutdown_req_n_out(sd_out), .shutdown_req_n_oe(sd_oe), .sleep_indicator_n(sleep_n),
        .recovery_strap_n(strap_n), .thermal_unsafe(therm), .sw_shutdown_req(sw_sd), .sw_running(sw_run),
        .undervoltage(uv), .sleep_req(slp), .deep_sleep_req(dslp), .temp_out_of_limits(temp),
        .vbus_detect(vbus), .vbus_wake_en(vbus_en), .internal_wake(iwake), .wake_pins(wp), .wake_pin_en(wpe),
        .live_outputs(live), .held_outputs(held), .soc_reset(soc_rst), .usb_recovery(usb_rec),
        .power_state(pstate));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic finish_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            err_total++;
            finish_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_st(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected state at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_st(input logic [1:0] exp, input int max);
        int i;
        for (i = 0; i < max && pstate !== exp; i++)
            step(1);
        chk_st(pstate, exp);
    endtask

    // The strap is set before the supply comes up so it is stable when reset is released.
    task automatic boot(input logic s);
        go = 1'b0;
        step(2);
        strap_n = s;
        go = 1'b1;
        wait_st(MPS_PWRUP, 12);
        chk_val(8'(rst_oe), 8'h01);
        wait_st(MPS_ON, 20);
        chk_val(8'(rst_oe), 8'h00);
        chk_val(8'(soc_rst), 8'h00);
        // The released reset wire needs four cycles through the synchroniser and one more to be latched.
        step(6);
        chk_val(8'(usb_rec), 8'(!s));
    endtask

    initial
    begin
        {go, off_req, ign, therm, sw_sd, sw_run, uv, slp, dslp, temp, vbus, vbus_en, iwake} = '0;
        {wp, wpe, live} = '0;
        strap_n = 1'b1;
        reset = 1'b1;
        void'($urandom(32'hD0B6));
        step(3);
        reset = 1'b0;
        chk_st(pstate, MPS_OFF);
        chk_val(8'(rst_oe), 8'h01);
        chk_val(8'(sleep_n), 8'h01);
        chk_val(8'({rst_out, sd_out}), 8'h00);
        boot(1'b1);
        off_req = 1'b1;
        step(100);
        off_req = 1'b0;
        step(10);
        chk_st(pstate, MPS_ON);
        off_req = 1'b1;
        step(240);
        chk_st(pstate, MPS_ON);
        wait_st(MPS_OFF, 40);
        chk_val(8'(rst_oe), 8'h01);
        chk_val(8'(soc_rst), 8'h01);
        go = 1'b0;
        off_req = 1'b0;
        boot(1'b0);
        for (k = 0; k < 4; k++)
        begin
            live = 8'($urandom);
            step(3);
            hexp = live;
            slp = 1'b1;
            dslp = k[0];
            wait_st(MPS_SLEEP, 5);
            slp = 1'b0;
            chk_val(8'(sleep_n), 8'(!dslp));
            dslp = 1'b0;
            live = ~hexp;
            step(5);
            chk_val(held, hexp);
            vbus = 1'b1;
            step(20);
            chk_st(pstate, MPS_SLEEP);
            case (k)
                0: vbus_en = 1'b1;
                1: temp = 1'b1;
                2: iwake = 1'b1;
                default: {wp, wpe} = {2{4'h1 << $urandom_range(3)}};
            endcase
            wait_st(MPS_ON, 10);
            {vbus, vbus_en, temp, iwake, wp, wpe} = '0;
            step(2);
            chk_val(8'(sleep_n), 8'h01);
            chk_val(held, live);
        end
        sw_sd = 1'b1;
        step(10);
        chk_val(8'(sd_oe), 8'h00);
        sw_sd = 1'b0;
        // Each shutdown pass boots from OFF, so the carrier first takes the module down.
        off_req = 1'b1;
        wait_st(MPS_OFF, 300);
        off_req = 1'b0;
        for (k = 0; k < 3; k++)
        begin
            boot(1'b1);
            ign = 1'b1;
            sw_run = 1'b1;
            case (k)
                0: sw_sd = 1'b1;
                1: therm = 1'b1;
                default: uv = 1'b1;
            endcase
            step(4);
            chk_val(8'(sd_oe), 8'h01);
            step(300);
            chk_st(pstate, MPS_ON);
            chk_val(8'(sup_en), 8'h01);
            ign = 1'b0;
            wait_st(MPS_OFF, 300);
            {sw_sd, therm, uv, sw_run} = '0;
            step(2);
            chk_val(8'(sup_en), 8'h00);
        end
        finish_test();
    end
endmodule
